// *** rtl/axis_wrap_and_reverse_limit.v ***
// Per-axis position wrap within a repeat span plus a selectable reverse limit.
// Assumes one clock, synchronous inputs, AXI4-Lite master with one access at a time.
// Summary of operation
// - The repeat control register is zero after reset.
// - With control bit 0 clear, the measured position stays between minus span and plus span.
// - With control bit 0 set, the measured position stays between zero and span.
// - Once the repeat is switched off, hardware clears control bit 1 itself.
// - Limit select values 0 to 31 each choose a valid input.
// - Inputs 0 to 15 are the unit connector inputs, shared by all axes.
// - Inputs 16 to 31 are this axis's own servo driver inputs.
// - Limit select resets to minus one, meaning no limit is watched.
// - While the selected limit is reached, reverse motion is stopped.
// - Reaching the selected limit sets bit 5 of the axis state word.
// - The selected limit input is active low.
// - When measured position hits the span, the wrap shifts both positions intact.
`timescale 1ns/1ps
`include "axis_wrap_consts.vh"

module axis_wrap_and_reverse_limit #(
  parameter TICK_DIV = `SERVO_PERIOD_NS / `CLK_PERIOD_NS  // Clocks per servo cycle
) (
  input  wire        clk_sys,        // System clock, 40 MHz
  input  wire        sys_rst,        // Synchronous reset, active high
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,   // Write address
  input  wire        s_axi_awvalid,  // Write address valid
  output reg         s_axi_awready,  // Write address ready
  input  wire [31:0] s_axi_wdata,    // Write data
  input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire        s_axi_wvalid,   // Write data valid
  output reg         s_axi_wready,   // Write data ready
  output reg  [1:0]  s_axi_bresp,    // Write response
  output reg         s_axi_bvalid,   // Write response valid
  input  wire        s_axi_bready,   // Write response ready
  input  wire [7:0]  s_axi_araddr,   // Read address
  input  wire        s_axi_arvalid,  // Read address valid
  output reg         s_axi_arready,  // Read address ready
  output reg  [31:0] s_axi_rdata,    // Read data
  output reg  [1:0]  s_axi_rresp,    // Read response
  output reg         s_axi_rvalid,   // Read data valid
  input  wire        s_axi_rready,   // Read data ready
  // Motion side
  input  wire [15:0] unitInN,        // Unit connector inputs, active low
  input  wire [15:0] driverInN,      // Servo driver inputs, active low
  input  wire [31:0] demandStep,     // Signed demand increment per servo cycle
  input  wire [31:0] measuredStep,   // Signed measured increment per servo cycle
  input  wire        repeatDone,     // Move engine: automatic repeat now off
  output reg         revInhibit_q,   // Block reverse motion
  output reg         repeatEndReq_q, // End-of-repeat request to move engine
  output reg         irq_q           // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Servo cycle divider
  // One tick per servo cycle; every per-cycle action keys off it
  // The count restarts on reset, so the first tick is TICK_DIV clocks in
  reg  [15:0] divCnt_q;
  reg         servoTick_q;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      divCnt_q    <= 16'h0000;
      servoTick_q <= 1'b0;
    end else if (divCnt_q == TICK_DIV[15:0] - 16'h0001) begin
      divCnt_q    <= 16'h0000;
      servoTick_q <= 1'b1;
    end else begin
      divCnt_q    <= divCnt_q + 16'h0001;
      servoTick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // All software state sits in flops; reads come from one shared mux
  // Positions are signed, two's complement, in user units
  reg  [1:0]  repCtrl_q;      // Bit0 range mode, bit1 end-repeat request
  reg  [31:0] repSpan_q;
  reg  [5:0]  revSel_q;
  reg  [31:0] demandPos_q;
  reg  [31:0] measuredPos_q;
  reg  [2:0]  irqStat_q;
  reg  [2:0]  irqEn_q;
  reg         moveRev_q;      // Software direction: 1 asks reverse
  reg  [31:0] axisState_q;

  wire        limitHit;
  wire [31:0] measNext;
  wire [31:0] demNext;
  wire [31:0] twoSpan;
  wire        wrapHigh;
  wire        wrapLow;
  wire        doWrite;
  reg  [7:0]  wAddr_q;
  reg  [31:0] wData_q;
  reg  [3:0]  wStrb_q;
  reg         awHeld_q;
  reg         wHeld_q;
  wire [31:0] wMerged;
  reg  [31:0] rData_d;
  reg         rErr_d;
  reg  [2:0]  irqEvt_d;

  // Limit selector; its output already carries one tick of sampling lag
  rev_limit_select uSelect (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .servoTick   (servoTick_q),
    .selectIndex (revSel_q),
    .unitInN     (unitInN),
    .driverInN   (driverInN),
    .limitHit_q  (limitHit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wrap test on the measured position; demand may sit outside the range
  assign measNext = measuredPos_q + measuredStep;
  assign demNext  = demandPos_q + demandStep;
  assign twoSpan  = {repSpan_q[30:0], 1'b0};
  assign wrapHigh = ($signed(measNext) >= $signed(repSpan_q));
  // Low bound is minus span or zero depending on mode
  assign wrapLow  = repCtrl_q[`BIT_RANGE_POSITIVE] ?
                    ($signed(measNext) < 0) :
                    ($signed(measNext) < -$signed(repSpan_q));

  // Subtract twice the span at span; positive-range mode shifts by one span
  // Demand moves through the same shift as measured, so the gap between
  // them, and with it the servo error, survives the wrap untouched
  // A step larger than the span can leave the position out of range
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      demandPos_q   <= 32'h0000_0000;
      measuredPos_q <= 32'h0000_0000;
    end else if (servoTick_q) begin
      if (wrapHigh) begin
        if (repCtrl_q[`BIT_RANGE_POSITIVE]) begin
          measuredPos_q <= measNext - repSpan_q;
          demandPos_q   <= demNext - repSpan_q;
        end else begin
          measuredPos_q <= measNext - twoSpan;
          demandPos_q   <= demNext - twoSpan;
        end
      end else if (wrapLow) begin
        if (repCtrl_q[`BIT_RANGE_POSITIVE]) begin
          measuredPos_q <= measNext + repSpan_q;
          demandPos_q   <= demNext + repSpan_q;
        end else begin
          measuredPos_q <= measNext + twoSpan;
          demandPos_q   <= demNext + twoSpan;
        end
      end else begin
        measuredPos_q <= measNext;
        demandPos_q   <= demNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reverse inhibit and axis state word; limit sticks in bit 5 while low
  // Only reverse requests are blocked, so the axis can still back off forward
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      revInhibit_q <= 1'b0;
      axisState_q  <= 32'h0000_0000;
    end else begin
      revInhibit_q <= limitHit & moveRev_q;
      axisState_q  <= {26'h000_0000, limitHit, 5'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channel: accept address and data in either order
  // The read mux and the write merge share one address path, so a commit
  // waits out the cycle in which the read address is being taken; arready
  // is a one-cycle pulse, so the write is held back one cycle at most
  assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid & ~s_axi_arready;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      wAddr_q       <= 8'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~awHeld_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHeld_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q <= 1'b1;
        wAddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wAddr_q > `REG_MOVE_CTRL || wAddr_q[1:0] != 2'b00) ?
                        `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte-lane merge of write data into the addressed register
  // Lanes without a strobe keep what the register holds now
  assign wMerged = {wStrb_q[3] ? wData_q[31:24] : rData_d[31:24],
                    wStrb_q[2] ? wData_q[23:16] : rData_d[23:16],
                    wStrb_q[1] ? wData_q[15:8]  : rData_d[15:8],
                    wStrb_q[0] ? wData_q[7:0]   : rData_d[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: wrap, limit reached, repeat ended
  // Each event is one cycle wide; only the status bit keeps it
  always @* begin
    irqEvt_d = 3'h0;
    irqEvt_d[`BIT_IRQ_WRAP]       = servoTick_q & (wrapHigh | wrapLow);
    irqEvt_d[`BIT_IRQ_REV_LIMIT]  = servoTick_q & limitHit;
    irqEvt_d[`BIT_IRQ_REPEAT_END] = repeatDone & repCtrl_q[`BIT_END_REPEAT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; hardware set of a flag beats a same-cycle clear
  // A control write wins over a same-cycle repeat end, so a fresh request
  // from software is never lost to an older report from the engine
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      repCtrl_q <= `RST_REPEAT_CONTROL;
      repSpan_q <= `RST_REPEAT_SPAN;
      revSel_q  <= `RST_REV_SELECT;
      irqStat_q <= 3'h0;
      irqEn_q   <= 3'h0;
      moveRev_q <= 1'b0;
    end else begin
      if (doWrite && wAddr_q == `REG_REPEAT_CONTROL) begin
        repCtrl_q <= wMerged[1:0];
      end else if (repeatDone) begin
        repCtrl_q[`BIT_END_REPEAT] <= 1'b0;
      end
      // Span of zero is meaningless; keep the old value
      if (doWrite && wAddr_q == `REG_REPEAT_SPAN && wMerged != 32'h0000_0000 &&
          !wMerged[31]) begin
        repSpan_q <= wMerged;
      end
      if (doWrite && wAddr_q == `REG_REV_SELECT) begin
        revSel_q <= wMerged[5:0];
      end
      if (doWrite && wAddr_q == `REG_IRQ_ENABLE) begin
        irqEn_q <= wMerged[2:0];
      end
      if (doWrite && wAddr_q == `REG_MOVE_CTRL) begin
        moveRev_q <= wMerged[0];
      end
      if (doWrite && wAddr_q == `REG_IRQ_CLEAR) begin
        irqStat_q <= (irqStat_q & ~wMerged[2:0]) | irqEvt_d;
      end else begin
        irqStat_q <= irqStat_q | irqEvt_d;
      end
    end
  end

  // Request to the move engine mirrors control bit 1
  // It drops one cycle after the engine reports done, not two cycles later
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      repeatEndReq_q <= 1'b0;
      irq_q          <= 1'b0;
    end else begin
      repeatEndReq_q <= repCtrl_q[`BIT_END_REPEAT] & ~repeatDone;
      irq_q          <= |(irqStat_q & irqEn_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, shared with the write byte merge (keyed by the live address)
  // Unmapped or misaligned offsets answer an error and read as zero
  always @* begin
    rData_d = 32'h0000_0000;
    rErr_d  = 1'b0;
    case (doWrite ? wAddr_q : s_axi_araddr)
      `REG_REPEAT_CONTROL: rData_d = {30'h0000_0000, repCtrl_q};
      `REG_REPEAT_SPAN:    rData_d = repSpan_q;
      `REG_REV_SELECT:     rData_d = {{26{revSel_q[5]}}, revSel_q};
      `REG_AXIS_STATE:     rData_d = axisState_q;
      `REG_DEMAND_POS:     rData_d = demandPos_q;
      `REG_MEASURED_POS:   rData_d = measuredPos_q;
      `REG_IRQ_STATUS:     rData_d = {29'h0000_0000, irqStat_q};
      `REG_IRQ_ENABLE:     rData_d = {29'h0000_0000, irqEn_q};
      `REG_IRQ_CLEAR:      rData_d = 32'h0000_0000;
      `REG_MOVE_CTRL:      rData_d = {31'h0000_0000, moveRev_q};
      default:             rErr_d  = 1'b1;
    endcase
  end

  // AXI read channel: address taken, data one cycle later
  // Data is captured at the address handshake, so a read shows the
  // registers as they stood one cycle before the answer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid & ~doWrite;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rData_d;
        s_axi_rresp  <= rErr_d ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // axis_wrap_and_reverse_limit

// *** rtl/axis_wrap_consts.vh ***
// Constants for the axis wrap and reverse limit block.
// Assumes inclusion by the block's Verilog-2005 files and by the bench top.
`ifndef AXIS_WRAP_CONSTS_VH
`define AXIS_WRAP_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define REG_REPEAT_CONTROL 8'h00
`define REG_REPEAT_SPAN    8'h04
`define REG_REV_SELECT     8'h08
`define REG_AXIS_STATE     8'h0C
`define REG_DEMAND_POS     8'h10
`define REG_MEASURED_POS   8'h14
`define REG_IRQ_STATUS     8'h18
`define REG_IRQ_ENABLE     8'h1C
`define REG_IRQ_CLEAR      8'h20
`define REG_MOVE_CTRL      8'h24

// Field positions
`define BIT_RANGE_POSITIVE 0
`define BIT_END_REPEAT     1
`define BIT_REV_LIMIT      5
`define BIT_IRQ_WRAP       0
`define BIT_IRQ_REV_LIMIT  1
`define BIT_IRQ_REPEAT_END 2

// Reset values
`define RST_REPEAT_CONTROL 2'h0
`define RST_REPEAT_SPAN    32'h004C_4B40
`define RST_REV_SELECT     6'h3F

// Timing: servo cycle period in ns, and the system clock period in ns
`define SERVO_PERIOD_NS    1000
`define CLK_PERIOD_NS      25

// AXI response codes
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// *** rtl/rev_limit_select.v ***
// Reverse limit input selector: picks one of 32 inputs for one axis.
// Assumes inputs are synchronous to clk_sys; sampled on each servo tick.
`timescale 1ns/1ps
`include "axis_wrap_consts.vh"

module rev_limit_select (
  input  wire        clk_sys,     // System clock
  input  wire        sys_rst,     // Synchronous reset, active high
  input  wire        servoTick,   // One-cycle servo cycle enable
  input  wire [5:0]  selectIndex, // Selected input, all ones means none
  input  wire [15:0] unitInN,     // Shared connector inputs, active low
  input  wire [15:0] driverInN,   // This axis's driver inputs, active low
  output reg         limitHit_q   // Selected limit asserted, sampled per tick
);

  wire [31:0] allInN;
  wire        validSel;

  // Low 16 shared by all axes, high 16 unique per axis
  assign allInN   = {driverInN, unitInN};
  // Only 0..31 are valid; minus one (all ones) disables monitoring
  assign validSel = ~selectIndex[5];

  ////////////////////////////////////////////////////////////////////////////
  // Sample once per servo cycle; low level means limit reached
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      limitHit_q <= 1'b0;
    end else if (servoTick) begin
      limitHit_q <= validSel & ~allInN[selectIndex[4:0]];
    end
  end

endmodule // rev_limit_select

// *** tb/axis_wrap_and_reverse_limit_monitor.sv ***
// Checker for the axis wrap and reverse limit block, watching its top ports.
// Assumes a single bus master and limit inputs synchronous to clk_sys.
`timescale 1ns/1ps
module axis_wrap_and_reverse_limit_monitor #(
  parameter TICK_DIV = 40  // Clocks per servo cycle
) (
  input wire logic        clk_sys,        // System clock
  input wire logic        sys_rst,        // Synchronous reset
  input wire logic        s_axi_awvalid,  // Write address valid
  input wire logic        s_axi_awready,  // Write address ready
  input wire logic        s_axi_wvalid,   // Write data valid
  input wire logic        s_axi_wready,   // Write data ready
  input wire logic        s_axi_bvalid,   // Write response valid
  input wire logic        s_axi_arvalid,  // Read address valid
  input wire logic        s_axi_arready,  // Read address ready
  input wire logic        s_axi_rvalid,   // Read data valid
  input wire logic [15:0] unitInN,        // Connector inputs
  input wire logic [15:0] driverInN,      // Driver inputs
  input wire logic        repeatDone,     // Move engine repeat off
  input wire logic        revInhibit_q,   // Reverse blocked
  input wire logic        repeatEndReq_q, // End of repeat request
  input wire logic        irq_q           // Interrupt
);
  logic [7:0] highCnt_q;  // Cycles with every limit input idle
  wire        hsW = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Saturating count, so a stale inhibit long after release is caught
  always @(posedge clk_sys) begin
    if (sys_rst || !(&{unitInN, driverInN})) highCnt_q <= 8'h00;
    else if (highCnt_q != 8'hFF) highCnt_q <= highCnt_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Rules on the ports
  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !irq_q && !revInhibit_q && !repeatEndReq_q)
    else $error("outputs not idle after reset");
  chk_limit_cause: assert property (revInhibit_q |-> highCnt_q < TICK_DIV + 3)
    else $error("reverse inhibit without an active low input");
  chk_repeat_clear: assert property (
    repeatDone && !s_axi_wvalid |-> ##[1:3] !repeatEndReq_q)
    else $error("end request not cleared by move engine");
  chk_end_request: assert property (
    $rose(repeatEndReq_q) |->
      $past(s_axi_wvalid, 1) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("end request rose without a write");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  chk_bvalid_cause: assert property ($rose(s_axi_bvalid) |-> $past(hsW, 1) || $past(hsW, 2))
    else $error("write response without a transfer");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  cover property ($rose(revInhibit_q));
  cover property ($rose(irq_q));
  cover property ($fell(repeatEndReq_q));
endmodule // axis_wrap_and_reverse_limit_monitor

bind axis_wrap_and_reverse_limit axis_wrap_and_reverse_limit_monitor #(.TICK_DIV(TICK_DIV))
  mon_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .unitInN(unitInN), .driverInN(driverInN),
  .repeatDone(repeatDone), .revInhibit_q(revInhibit_q), .repeatEndReq_q(repeatEndReq_q),
  .irq_q(irq_q));

// *** tb/axis_wrap_and_reverse_limit_tb_top.sv ***
// Self-checking bench: AXI4-Lite master, limit input model, queued read checks.
// Assumes the shortened servo cycle TD so that a run stays brief.
`timescale 1ns/1ps
`include "axis_wrap_consts.vh"
module axis_wrap_and_reverse_limit_tb_top;
  localparam TD = 4;
  logic        clk_sys = 0, sys_rst = 1, repeatDone = 0, actOn = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, demandStep = 0, measuredStep = 0, rng = 32'hb275_f697;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [4:0]  actIdx = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         revInhibit_q, repeatEndReq_q, irq_q;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  unitInN, driverInN;
  int          err_count = 0, compares = 0;
  logic [65:0] expQ[$];  // {resp, mask, data} of each read in flight

  always #12.5 clk_sys = ~clk_sys;
  axis_wrap_and_reverse_limit #(.TICK_DIV(TD)) dut_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .unitInN(unitInN), .driverInN(driverInN),
    .demandStep(demandStep), .measuredStep(measuredStep), .repeatDone(repeatDone),
    .revInhibit_q(revInhibit_q), .repeatEndReq_q(repeatEndReq_q), .irq_q(irq_q));
  limit_input_model part_u (.clk_sys(clk_sys), .actOn(actOn), .actIdx(actIdx),
    .unitInN(unitInN), .driverInN(driverInN));
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tmo(input string nm);
    err_count++;
    $display("MISMATCH %s expected answer seen timeout", nm);
    final_report;
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, b;
    aw = 0; w = 0; b = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 60 && !b; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) begin aw = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin w = 1; s_axi_wvalid <= 0; end
      b = s_axi_bvalid;
    end
    if (!b) tmo("bvalid");
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 0;
  endtask
  // Read: expectation queued here, judged by the watcher below
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
          input logic [1:0] er, output logic [31:0] d);
    int n;
    logic r;
    r = 0;
    @(posedge clk_sys);
    expQ.push_back({er, m, e});
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (n = 0; n < 60 && !r; n++) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      r = s_axi_rvalid;
    end
    if (!r) tmo("rvalid");
    d = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
  task waitOut(input int which, input logic e, input string nm);
    int n;
    logic v;
    for (n = 0; n < 12 * TD; n++) begin
      @(posedge clk_sys);
      v = (which == 0) ? revInhibit_q : (which == 1) ? irq_q : repeatEndReq_q;
      if (v === e) break;
    end
    chk(nm, e, v);
    if (v !== e) final_report;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Read watcher: oldest expectation against each completed read
  always @(posedge clk_sys) begin
    if (!sys_rst && s_axi_rvalid && s_axi_rready) begin
      if (expQ.size() == 0) chk("readQueue", 1, 0);
      else begin
        chk("rresp", expQ[0][65:64], s_axi_rresp);
        chk("rdata", expQ[0][31:0] & expQ[0][63:32], s_axi_rdata & expQ[0][63:32]);
        void'(expQ.pop_front());
      end
    end
  end
  initial begin repeat (60000) @(posedge clk_sys); tmo("run"); end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d, prev;
    int i, k, sp, t, moved, idx[6];
    idx = '{0, 7, 15, 16, 23, 31};
    repeat (10) @(posedge clk_sys);
    sys_rst <= 0;
    rd(`REG_REPEAT_CONTROL, 0, 32'h0000_0003, `RESP_OKAY, d);
    rd(`REG_REV_SELECT, 32'hFFFF_FFFF, 32'hFFFF_FFFF, `RESP_OKAY, d);
    rd(`REG_REPEAT_SPAN, 32'h004C_4B40, 32'hFFFF_FFFF, `RESP_OKAY, d);
    rd(8'h40, 0, 32'hFFFF_FFFF, `RESP_SLVERR, d);
    wr(8'h40, 32'h1234_5678, `RESP_SLVERR);
    $display("test reset and map done");
    wr(`REG_MOVE_CTRL, 32'h0000_0001, `RESP_OKAY);
    wr(`REG_IRQ_ENABLE, 32'h0000_0002, `RESP_OKAY);
    actIdx <= 5'd3; actOn <= 1;
    repeat (3 * TD) @(posedge clk_sys);
    chk("noSelect", 0, revInhibit_q);
    actOn <= 0;
    for (i = 0; i < 6; i++) begin
      wr(`REG_REV_SELECT, idx[i], `RESP_OKAY);
      actIdx <= idx[i] ^ 16; actOn <= 1;
      repeat (3 * TD) @(posedge clk_sys);
      chk("otherBank", 0, revInhibit_q);
      actIdx <= idx[i];
      waitOut(0, 1, "revInhibit");
      rd(`REG_AXIS_STATE, 32'h0000_0020, 32'h0000_0020, `RESP_OKAY, d);
      actOn <= 0;
      waitOut(0, 0, "revRelease");
    end
    waitOut(1, 1, "irqRaise");
    wr(`REG_IRQ_ENABLE, 0, `RESP_OKAY);
    waitOut(1, 0, "irqMask");
    wr(`REG_IRQ_ENABLE, 32'h0000_0002, `RESP_OKAY);
    waitOut(1, 1, "irqUnmask");
    wr(`REG_IRQ_CLEAR, 32'h0000_0002, `RESP_OKAY);
    waitOut(1, 0, "irqClear");
    rd(`REG_IRQ_STATUS, 0, 32'h0000_0002, `RESP_OKAY, d);
    $display("test reverse limit done");
    wr(`REG_REPEAT_CONTROL, 32'h0000_0003, `RESP_OKAY);
    waitOut(2, 1, "endRequest");
    rd(`REG_REPEAT_CONTROL, 32'h0000_0003, 32'h0000_0003, `RESP_OKAY, d);
    @(posedge clk_sys) repeatDone <= 1;
    @(posedge clk_sys) repeatDone <= 0;
    waitOut(2, 0, "endCleared");
    rd(`REG_REPEAT_CONTROL, 32'h0000_0001, 32'h0000_0003, `RESP_OKAY, d);
    $display("test repeat end done");
    // Random steps; from the third sample on, each must sit inside the window of the mode
    for (k = 0; k < 2; k++) begin
      rng = xs(rng);
      sp = 1000 + int'(rng[7:0]);
      wr(`REG_REPEAT_SPAN, sp, `RESP_OKAY);
      wr(`REG_REPEAT_CONTROL, k, `RESP_OKAY);
      moved = 0;
      prev = 0;
      for (i = 0; i < 10; i++) begin
        rng = xs(rng);
        t = int'(rng[15:0]) % sp - sp / 2;
        measuredStep <= t; demandStep <= t + 1;
        repeat (2 * TD) @(posedge clk_sys);
        rd(`REG_MEASURED_POS, 0, 0, `RESP_OKAY, d);
        if (i > 1) chk("posRange", 1,
                       $signed(d) >= (k ? 0 : -sp) && $signed(d) < sp);
        if (i > 1 && d !== prev) moved = 1;
        prev = d;
      end
      chk("posMoves", 1, moved);
    end
    // A step just under the span forces a wrap within two ticks
    measuredStep <= sp - 1;
    repeat (2 * TD) @(posedge clk_sys);
    rd(`REG_IRQ_STATUS, 32'h0000_0005, 32'h0000_0007, `RESP_OKAY, d);
    $display("test wrap done");
    final_report;
  end
endmodule // axis_wrap_and_reverse_limit_tb_top

// *** tb/limit_input_model.sv ***
// Model of the connector and servo driver limit inputs of one axis.
// Assumes one input at a time is held active; idle lines sit on pull-ups.
`timescale 1ns/1ps
module limit_input_model (
  input  wire logic        clk_sys,   // System clock
  input  wire logic        actOn,     // Hold the chosen input active
  input  wire logic [4:0]  actIdx,    // Input number 0 to 31
  output      logic [15:0] unitInN,   // Shared connector inputs
  output      logic [15:0] driverInN  // This axis's driver inputs
);
  initial begin unitInN = 16'hFFFF; driverInN = 16'hFFFF; end
  ////////////////////////////////////////////////////////////////////////////////
  // Switch closes to ground; levels move just after the edge like real wiring
  always @(posedge clk_sys) begin
    unitInN   <= 16'hFFFF;
    driverInN <= 16'hFFFF;
    if (actOn && !actIdx[4]) unitInN[actIdx[3:0]] <= 1'b0;
    if (actOn && actIdx[4]) driverInN[actIdx[3:0]] <= 1'b0;
  end
endmodule // limit_input_model
